// File: common/usbsr_pkg.sv
// constants and types for the usb device suspend and resume block
package usbsr_pkg;
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned IDLE_SUSP_US    = 3000;
	localparam int unsigned CLK_STOP_US     = 2000;
	localparam int unsigned WAKE_BLOCK_US   = 5000;
	localparam int unsigned REMOTE_K_US     = 10000;
	localparam int unsigned RESUME_US       = 5000;
	localparam int unsigned RESUME_FAST_US  = 100;
	localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int unsigned IDLE_SUSP_CYC   = IDLE_SUSP_US * CYC_PER_US;
	localparam int unsigned CLK_STOP_CYC    = CLK_STOP_US * CYC_PER_US;
	localparam int unsigned WAKE_BLOCK_CYC  = WAKE_BLOCK_US * CYC_PER_US;
	localparam int unsigned REMOTE_K_CYC    = REMOTE_K_US * CYC_PER_US;
	localparam int unsigned RESUME_CYC      = RESUME_US * CYC_PER_US;
	localparam int unsigned RESUME_FAST_CYC = RESUME_FAST_US * CYC_PER_US;
	localparam int unsigned CNT_W           = 17;
	localparam logic        FLAG_RESET      = 1'b0;
	// idle levels of the synced pins: vbus, wake pin and chip select high
	localparam logic [6:0]  SYNC_IDLE       = 7'h16;

	typedef enum logic [4:0] {
		USBSR_ACTIVE   = 5'b0_0001,
		USBSR_SUSP_RUN = 5'b0_0010,
		USBSR_SUSP_OFF = 5'b0_0100,
		USBSR_WAKE_OSC = 5'b0_1000,
		USBSR_WAKE_RUN = 5'b1_0000
	} usbsr_state_t;
endpackage : usbsr_pkg

// File: common/usbsr_tmr_if.sv
// timer load and expiry signals between controller and its timer
`timescale 1ns/1ns
interface usbsr_tmr_if;
	import usbsr_pkg::*;
	logic             load;
	logic [CNT_W-1:0] value;
	logic             expired;
	modport ctrl (output load, output value, input expired);
	modport tmr  (input load, input value, output expired);
endinterface : usbsr_tmr_if

// File: rtl/usbsr_ctrl.sv
// suspend and wake-up control of the usb peripheral controller
// Overview of operation
// - suspend condition is 3 ms of continuous bus idle or loss of bus power
// - no start-of-frame for 3 ms sets suspend flag; interrupt only if enabled
// - bus state flag reads 0 once bus is active; firmware then aborts suspend
// - set-then-clear strobe enters suspend, pin high, clocks stop 2 ms later if the clock run bit is clear at that point
// - wake-up events are ignored for the first 5 ms of suspend
// - wake on host K-state, pin low pulse, or enabled chip-select low pulse
// - remote wake drives K-state on the bus for 10 ms
// - oscillator and pll restart first; clocks routed only once stable
// - wake releases pin (output enable drops with suspend) and sets wake flag; interrupt only if enabled
// - normal operation 5 ms after wake start, 100 us with test pin high
// - registers locked after wake until firmware sends the unlock command in normal operation
`timescale 1ns/1ns
module usbsr_ctrl
	import usbsr_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	// usb line status (pins)
	input  wire logic bus_idle_i,
	input  wire logic sof_seen_i,
	input  wire logic vbus_present_i,
	input  wire logic bus_k_state_i,
	// application wake pins
	input  wire logic sleep_wake_pin_i,
	input  wire logic chip_select_n_i,
	input  wire logic fast_wake_test_pin_i,
	// firmware control bits
	input  wire logic enter_sleep_strobe_i,
	input  wire logic clock_run_bit_i,
	input  wire logic select_wake_enable_i,
	input  wire logic suspend_irq_enable_i,
	input  wire logic wake_irq_enable_i,
	input  wire logic suspend_flag_clr_i,
	input  wire logic wake_flag_clr_i,
	input  wire logic unlock_cmd_i,
	// clock generator handshake
	input  wire logic osc_stable_i,
	// status to firmware
	output logic      suspend_flag_o,
	output logic      wake_flag_o,
	output logic      bus_state_flag_o,
	output logic      irq_o,
	output logic      regs_locked_o,
	output logic      suspended_o,
	// clock and bus control
	output logic      osc_enable_o,
	output logic      clk_route_o,
	output logic      drive_k_state_o,
	// sleep/wake pin
	output logic      sleep_wake_pin_o,
	output logic      sleep_wake_pin_oe_o
);
	// two-flop synchronisers for all pin inputs
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	assign pin_raw = {bus_idle_i, sof_seen_i, vbus_present_i, bus_k_state_i,
		sleep_wake_pin_i, chip_select_n_i, fast_wake_test_pin_i};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge sys_clk_i or posedge reset_i) begin
				// idle level at reset, else a fake vbus drop or wake edge
				if (reset_i) begin
					sync_a[gi] <= SYNC_IDLE[gi];
					sync_b[gi] <= SYNC_IDLE[gi];
				end else begin
					sync_a[gi] <= pin_raw[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	logic idle_s, sof_s, vbus_s, kst_s, pin_s, cs_n_s, test_s;
	assign {idle_s, sof_s, vbus_s, kst_s, pin_s, cs_n_s, test_s} = sync_b;

	usbsr_state_t     state;
	usbsr_state_t     next_state;
	logic [CNT_W-1:0] idle_cnt;
	logic             idle_hit;
	logic             strobe_d;
	logic             strobe_fall;
	logic             blocked;
	logic             pin_d;
	logic             cs_d;
	logic             remote_ev;
	logic             wake_ev;
	logic             resume_due;
	logic             k_timing;
	logic [CNT_W-1:0] k_cnt;

	usbsr_tmr_if tmr_bus ();
	usbsr_timer u_timer (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.tmr       (tmr_bus.tmr)
	);

	// idle / no-sof counter; vbus loss counts as suspend at once
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			idle_cnt <= '0;
		end else if (!idle_s || sof_s) begin
			idle_cnt <= '0;
		end else if (idle_cnt != CNT_W'(IDLE_SUSP_CYC)) begin
			idle_cnt <= idle_cnt + 1'b1;
		end
	end
	// single pulse at the 3 ms mark; held high while vbus stays low once the bus state flag is set
	assign idle_hit = (idle_s && !sof_s &&
		idle_cnt == CNT_W'(IDLE_SUSP_CYC - 1)) || (!vbus_s && bus_state_flag_o);

	// bus state: 1 while suspend condition holds, 0 once bus is active again
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			bus_state_flag_o <= FLAG_RESET;
		end else if (idle_hit || !vbus_s) begin
			bus_state_flag_o <= 1'b1;
		end else if (!idle_s || sof_s) begin
			bus_state_flag_o <= 1'b0;
		end
	end

	// sticky flags; a set in the clear cycle wins
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			suspend_flag_o <= FLAG_RESET;
		end else if (idle_hit && state == USBSR_ACTIVE) begin
			suspend_flag_o <= 1'b1;
		end else if (suspend_flag_clr_i) begin
			suspend_flag_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wake_flag_o <= FLAG_RESET;
		end else if (state == USBSR_WAKE_OSC && osc_stable_i) begin
			wake_flag_o <= 1'b1;
		end else if (wake_flag_clr_i) begin
			wake_flag_o <= 1'b0;
		end
	end

	assign irq_o = (suspend_flag_o && suspend_irq_enable_i) ||
		(wake_flag_o && wake_irq_enable_i);

	// strobe must be set and then cleared; entry happens on the clear
	assign strobe_fall = strobe_d && !enter_sleep_strobe_i;

	// edge history: strobe fall, low wake pulses at their falling edge
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			strobe_d <= 1'b0;
			pin_d    <= 1'b1;
			cs_d     <= 1'b1;
		end else begin
			strobe_d <= enter_sleep_strobe_i;
			pin_d    <= pin_s;
			cs_d     <= cs_n_s;
		end
	end
	assign remote_ev = (pin_d && !pin_s) ||
		(select_wake_enable_i && cs_d && !cs_n_s);
	assign wake_ev = remote_ev || kst_s || !idle_s;

	// 5 ms blocking window from suspend entry
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			blocked <= 1'b0;
		end else if (state == USBSR_ACTIVE && strobe_fall) begin
			blocked <= 1'b1;
		end else if (k_cnt == '0 && suspended_o) begin
			blocked <= 1'b0;
		end
	end

	// separate counter for the 5 ms block, reused for the 10 ms k-state
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			k_cnt <= '0;
		end else if (state == USBSR_ACTIVE && strobe_fall) begin
			k_cnt <= CNT_W'(WAKE_BLOCK_CYC - 1);
		end else if (next_state == USBSR_WAKE_OSC && state != USBSR_WAKE_OSC &&
				remote_ev) begin
			k_cnt <= CNT_W'(REMOTE_K_CYC - 1);
		end else if (k_cnt != '0) begin
			k_cnt <= k_cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			k_timing <= 1'b0;
		end else if (next_state == USBSR_WAKE_OSC && state != USBSR_WAKE_OSC) begin
			k_timing <= remote_ev;
		end else if (k_cnt == '0) begin
			k_timing <= 1'b0;
		end
	end

	// state machine
	always_comb begin
		next_state = state;
		case (state)
			USBSR_ACTIVE: begin
				if (strobe_fall) next_state = USBSR_SUSP_RUN;
			end
			USBSR_SUSP_RUN: begin
				if (!blocked && wake_ev) begin
					next_state = USBSR_WAKE_OSC;
				end else if (tmr_bus.expired && !clock_run_bit_i) begin
					next_state = USBSR_SUSP_OFF;
				end
			end
			USBSR_SUSP_OFF: begin
				if (!blocked && wake_ev) next_state = USBSR_WAKE_OSC;
			end
			USBSR_WAKE_OSC: begin
				if (osc_stable_i) next_state = USBSR_WAKE_RUN;
			end
			USBSR_WAKE_RUN: begin
				if (tmr_bus.expired || resume_due) begin
					next_state = USBSR_ACTIVE;
				end
			end
			default: next_state = USBSR_ACTIVE;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= USBSR_ACTIVE;
		end else begin
			state <= next_state;
		end
	end

	// resume delay may run out before the oscillator settles; keep it
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			resume_due <= 1'b0;
		end else begin
			resume_due <= state == USBSR_WAKE_OSC &&
				(tmr_bus.expired || resume_due);
		end
	end

	// timer loads: 2 ms clock stop, then resume delay from wake start
	always_comb begin
		tmr_bus.load  = 1'b0;
		tmr_bus.value = '0;
		if (state == USBSR_ACTIVE && strobe_fall) begin
			tmr_bus.load  = 1'b1;
			tmr_bus.value = CNT_W'(CLK_STOP_CYC - 1);
		end else if (next_state == USBSR_WAKE_OSC && state != USBSR_WAKE_OSC) begin
			tmr_bus.load  = 1'b1;
			tmr_bus.value = test_s ? CNT_W'(RESUME_FAST_CYC - 1)
				: CNT_W'(RESUME_CYC - 1);
		end
	end

	// register lock set by wake, cleared by unlock command in the active state
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			regs_locked_o <= 1'b0;
		end else if (state == USBSR_WAKE_OSC) begin
			regs_locked_o <= 1'b1;
		end else if (unlock_cmd_i && state == USBSR_ACTIVE) begin
			regs_locked_o <= 1'b0;
		end
	end

	// outputs from flops
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			suspended_o      <= 1'b0;
			osc_enable_o     <= 1'b1;
			clk_route_o      <= 1'b1;
			drive_k_state_o  <= 1'b0;
			sleep_wake_pin_o <= 1'b0;
		end else begin
			suspended_o  <= next_state == USBSR_SUSP_RUN ||
				next_state == USBSR_SUSP_OFF;
			osc_enable_o <= next_state != USBSR_SUSP_OFF;
			clk_route_o  <= next_state == USBSR_ACTIVE ||
				next_state == USBSR_SUSP_RUN ||
				next_state == USBSR_WAKE_RUN;
			drive_k_state_o <= (k_timing && k_cnt != '0) ||
				(remote_ev && next_state == USBSR_WAKE_OSC &&
				state != USBSR_WAKE_OSC);
			sleep_wake_pin_o <= next_state == USBSR_SUSP_RUN ||
				next_state == USBSR_SUSP_OFF;
		end
	end
	// pin driven high only while suspended, released otherwise; pulses read back via input
	assign sleep_wake_pin_oe_o = suspended_o;
endmodule : usbsr_ctrl

// File: rtl/usbsr_timer.sv
// down counter that signals expiry once after a load
`timescale 1ns/1ns
module usbsr_timer
	import usbsr_pkg::*;
(
	// clock and reset
	input  wire logic  sys_clk_i,
	input  wire logic  reset_i,
	// controller side
	usbsr_tmr_if.tmr   tmr
);
	logic [CNT_W-1:0] count;
	logic             running;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			count   <= '0;
			running <= 1'b0;
		end else if (tmr.load) begin
			count   <= tmr.value;
			running <= 1'b1;
		end else if (running && count != '0) begin
			count <= count - 1'b1;
		end else begin
			running <= 1'b0;
		end
	end

	assign tmr.expired = running && count == '0 && !tmr.load;
endmodule : usbsr_timer

// File: verification/testbench.sv
// bench for the suspend and wake controller
`timescale 1ns/1ns
module testbench;
	import usbsr_pkg::*;
	logic sys_clk_i, reset_i, bus_idle_i, sof_seen_i, vbus_present_i;
	logic bus_k_state_i, sleep_wake_pin_i, chip_select_n_i, osc_stable_i;
	logic fast_wake_test_pin_i, enter_sleep_strobe_i, clock_run_bit_i;
	logic select_wake_enable_i, suspend_irq_enable_i, wake_irq_enable_i;
	logic suspend_flag_clr_i, wake_flag_clr_i, unlock_cmd_i, idle_req, pin_low;
	logic suspend_flag_o, wake_flag_o, bus_state_flag_o, irq_o, regs_locked_o;
	logic suspended_o, osc_enable_o, clk_route_o, drive_k_state_o;
	logic sleep_wake_pin_o, sleep_wake_pin_oe_o;
	logic k_req;
	int   fails, check_count;

	usbsr_ctrl DUT (.*);
	usbsr_host_model u_host (.sys_clk_i, .reset_i, .idle_req_i(idle_req),
		.resume_req_i(k_req),
		.bus_idle_o(bus_idle_i), .sof_seen_o(sof_seen_i),
		.bus_k_state_o(bus_k_state_i));
	// pulled-up pin: external low pulse beats the driven level
	assign sleep_wake_pin_i = pin_low ? 1'b0 :
		(sleep_wake_pin_oe_o ? sleep_wake_pin_o : 1'b1);

	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc

	task automatic chk(input string name, input logic exp, input logic got);
		#1;
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %b seen %b", name, exp, got);
		end
	endtask : chk

	task automatic pulse(input logic by_cs);
		if (by_cs)
			chip_select_n_i <= 1'b0;
		else
			pin_low <= 1'b1;
		cyc(4);
		chip_select_n_i <= 1'b1;
		pin_low <= 1'b0;
		cyc(4);
	endtask : pulse

	task automatic unlock();
		unlock_cmd_i <= 1'b1;
		cyc(1);
		unlock_cmd_i <= 1'b0;
		cyc(2);
	endtask : unlock

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	initial begin
		#9_800_000;
		fails++;
		test_done();
	end

	initial begin
		fails = 0;
		check_count = 0;
		{idle_req, k_req, pin_low, enter_sleep_strobe_i, clock_run_bit_i,
			select_wake_enable_i, suspend_flag_clr_i, wake_flag_clr_i,
			unlock_cmd_i} = '0;
		{reset_i, vbus_present_i, chip_select_n_i, osc_stable_i,
			fast_wake_test_pin_i, suspend_irq_enable_i, wake_irq_enable_i} = '1;
		cyc(10);
		reset_i <= 1'b0;
		cyc(5);
		chk("suspend_flag", 1'b0, suspend_flag_o);
		vbus_present_i <= 1'b0;
		cyc(6);
		chk("suspend_flag", 1'b1, suspend_flag_o);
		chk("bus_state", 1'b1, bus_state_flag_o);
		chk("irq", 1'b1, irq_o);
		vbus_present_i <= 1'b1;
		suspend_flag_clr_i <= 1'b1;
		cyc(6);
		suspend_flag_clr_i <= 1'b0;
		chk("suspend_flag", 1'b0, suspend_flag_o);
		$display("test vbus_loss done");
		// start idling right after a marker so both timers agree
		for (int i = 0; i < 10010 && sof_seen_i !== 1'b1; i++)
			cyc(1);
		suspend_irq_enable_i <= 1'b0;
		idle_req <= 1'b1;
		cyc(29980);
		chk("suspend_flag", 1'b0, suspend_flag_o);
		cyc(30);
		chk("suspend_flag", 1'b1, suspend_flag_o);
		chk("bus_state", 1'b1, bus_state_flag_o);
		chk("irq", 1'b0, irq_o);
		$display("test idle_detect done");
		enter_sleep_strobe_i <= 1'b1;
		cyc(1);
		enter_sleep_strobe_i <= 1'b0;
		cyc(2);
		chk("suspended", 1'b1, suspended_o);
		chk("wake_pin", 1'b1, sleep_wake_pin_o);
		cyc(20020);
		chk("osc_enable", 1'b0, osc_enable_o);
		chk("clk_route", 1'b0, clk_route_o);
		osc_stable_i <= 1'b0;
		cyc(29850);
		pulse(1'b0);
		chk("suspended", 1'b1, suspended_o);
		k_req <= 1'b1;
		cyc(4);
		k_req <= 1'b0;
		chk("suspended", 1'b1, suspended_o);
		cyc(150);
		pulse(1'b1);
		chk("suspended", 1'b1, suspended_o);
		pulse(1'b0);
		idle_req <= 1'b0;
		chk("suspended", 1'b0, suspended_o);
		chk("drive_k", 1'b1, drive_k_state_o);
		chk("osc_enable", 1'b1, osc_enable_o);
		chk("clk_route", 1'b0, clk_route_o);
		chk("wake_pin", 1'b0, sleep_wake_pin_o);
		osc_stable_i <= 1'b1;
		cyc(2);
		chk("clk_route", 1'b1, clk_route_o);
		chk("wake_flag", 1'b1, wake_flag_o);
		chk("irq", 1'b1, irq_o);
		chk("locked", 1'b1, regs_locked_o);
		$display("test suspend_wake done");
		cyc(880);
		unlock();
		chk("locked", 1'b1, regs_locked_o);
		cyc(130);
		unlock();
		chk("locked", 1'b0, regs_locked_o);
		chk("bus_state", 1'b0, bus_state_flag_o);
		wake_flag_clr_i <= 1'b1;
		cyc(2);
		wake_flag_clr_i <= 1'b0;
		chk("wake_flag", 1'b0, wake_flag_o);
		chk("irq", 1'b0, irq_o);
		$display("test resume_unlock done");
		test_done();
	end
endmodule : testbench

bind usbsr_ctrl usbsr_chk u_chk (.*);

// File: verification/usbsr_chk.sv
// port assertions for the suspend and wake controller
`timescale 1ns/1ns
module usbsr_chk
	import usbsr_pkg::*;
(
	// clock, reset and watched inputs
	input wire logic sys_clk_i, reset_i, vbus_present_i, enter_sleep_strobe_i,
	input wire logic clock_run_bit_i, suspend_irq_enable_i, wake_irq_enable_i,
	input wire logic unlock_cmd_i, osc_stable_i,
	// watched outputs
	input wire logic suspend_flag_o, wake_flag_o, bus_state_flag_o, irq_o,
	input wire logic regs_locked_o, suspended_o, osc_enable_o, clk_route_o,
	input wire logic drive_k_state_o, sleep_wake_pin_o, sleep_wake_pin_oe_o
);
	logic [16:0] susp_cnt;

	// saturates so a very long suspend cannot wrap back into the early window
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i || !suspended_o)
			susp_cnt <= 17'h0_0000;
		else if (susp_cnt != 17'h1_FFFF)
			susp_cnt <= susp_cnt + 17'h0_0001;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	pin_oe_match_a: assert property (sleep_wake_pin_oe_o == suspended_o)
		else $error("pin enable differs from suspend state");
	pin_high_susp_a: assert property (suspended_o |-> sleep_wake_pin_o)
		else $error("pin not high in suspend");
	irq_gating_a: assert property (irq_o == ((suspend_flag_o &&
		suspend_irq_enable_i) || (wake_flag_o && wake_irq_enable_i)))
		else $error("irq does not match flags and enables");
	vbus_loss_a: assert property ($fell(vbus_present_i) |-> ##[1:5]
		(suspend_flag_o && bus_state_flag_o))
		else $error("vbus loss not flagged");
	sleep_entry_a: assert property ($fell(enter_sleep_strobe_i) &&
		!suspended_o && clk_route_o && !regs_locked_o |=> suspended_o)
		else $error("strobe release did not enter suspend");
	clk_early_a: assert property (suspended_o &&
		susp_cnt < 17'h0_4E16 |-> osc_enable_o && clk_route_o)
		else $error("clocks stopped too early");
	clk_stop_a: assert property (suspended_o && susp_cnt == 17'h0_4E2A &&
		!clock_run_bit_i |-> !osc_enable_o)
		else $error("clocks still running after stop delay");
	wake_block_a: assert property (suspended_o &&
		susp_cnt < 17'h0_C346 |=> suspended_o)
		else $error("suspend left inside blocking window");
	wake_start_a: assert property ($fell(suspended_o) |->
		osc_enable_o && !sleep_wake_pin_o)
		else $error("wake start without oscillator or with pin high");
	route_stable_a: assert property ($rose(clk_route_o) |->
		$past(osc_stable_i) && wake_flag_o && regs_locked_o)
		else $error("clocks routed before stable or flags missing");
	k_hold_a: assert property ($rose(drive_k_state_o) |->
		drive_k_state_o[*8])
		else $error("remote wake drive too short");
	lock_hold_a: assert property (regs_locked_o && !unlock_cmd_i |=>
		regs_locked_o)
		else $error("lock dropped without unlock");

	cover property ($fell(osc_enable_o));
	cover property ($fell(suspended_o));
	cover property ($fell(regs_locked_o));
endmodule : usbsr_chk

// File: verification/usbsr_host_model.sv
// upstream host model: bus traffic and frame markers unless asked to idle
`timescale 1ns/1ns
module usbsr_host_model (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	// bench control
	input  wire logic idle_req_i,
	input  wire logic resume_req_i,
	// usb line status
	output logic      bus_idle_o,
	output logic      sof_seen_o,
	output logic      bus_k_state_o
);
	logic [13:0] frame_cnt;

	// one marker per 1 ms frame
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i || frame_cnt == 14'h270F)
			frame_cnt <= 14'h0000;
		else
			frame_cnt <= frame_cnt + 14'h0001;
	end
	assign sof_seen_o    = !idle_req_i && frame_cnt == 14'h0000;
	assign bus_idle_o    = idle_req_i;
	// global resume as a level, held as long as the bench asks
	assign bus_k_state_o = resume_req_i;
endmodule : usbsr_host_model
